//--- logic/ptd_defs.svh
// timebase divider constants: register offsets, fields, taps
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH
`define PTD_ADDR_W        4
`define PTD_OFF_CTRL      4'h0
`define PTD_OFF_STAT      4'h4
`define PTD_OFF_CNT       4'h8
`define PTD_BIT_ON        0
`define PTD_BIT_RANGE     1
`define PTD_BIT_IE        2
`define PTD_RATE_LSB      4
`define PTD_RATE_MSB      6
`define PTD_BIT_FLAG      0
`define PTD_BIT_FCLR      1
`define PTD_CNT_W         23
`define PTD_CNT_ONE       23'h000001
`define PTD_SYNC_WAIT     0
`define PTD_SYNC_STOP     1
`define PTD_SYNC_OSC      2
`define PTD_CTRL_RST      8'h00
`define PTD_ZERO8         8'h00
`define PTD_TAP_LO_0      23'h008000
`define PTD_TAP_LO_1      23'h002000
`define PTD_TAP_LO_2      23'h000800
`define PTD_TAP_LO_3      23'h000080
`define PTD_TAP_LO_4      23'h000040
`define PTD_TAP_LO_5      23'h000020
`define PTD_TAP_LO_6      23'h000010
`define PTD_TAP_LO_7      23'h000008
`define PTD_TAP_HI_0      23'h400000
`define PTD_TAP_HI_1      23'h100000
`define PTD_TAP_HI_2      23'h040000
`define PTD_TAP_HI_3      23'h004000
`define PTD_TAP_HI_4      23'h002000
`define PTD_TAP_HI_5      23'h001000
`define PTD_TAP_HI_6      23'h000800
`define PTD_TAP_HI_7      23'h000400
`endif

//--- logic/ptd_pkg.sv
// timebase divider types
`default_nettype none
package ptd_pkg;
  typedef logic [2:0] ptd_rate_t;
  typedef logic [22:0] ptd_cnt_t;
endpackage
`default_nettype wire

//--- logic/ptd_timebase.sv
// periodic timebase divider with register port and low-power gating
`include "ptd_defs.svh"
`default_nettype none
module ptd_timebase
(
  input  wire logic                   CLK,
  input  wire logic                   RST_B,
  input  wire logic                   CE,
  input  wire logic [`PTD_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [7:0]             RDATA,
  input  wire logic                   WAIT_MODE,
  input  wire logic                   STOP_MODE,
  input  wire logic                   OSC_RUN_IN_STOP_BIT,
  output logic                        IRQ,
  output logic                        WAKEUP
);
  function automatic ptd_pkg::ptd_cnt_t tap_of(input logic range,
                                               input ptd_pkg::ptd_rate_t r);
    ptd_pkg::ptd_cnt_t t;
    t = `PTD_TAP_LO_0;
    case ({range, r})
      4'h0: t = `PTD_TAP_LO_0;
      4'h1: t = `PTD_TAP_LO_1;
      4'h2: t = `PTD_TAP_LO_2;
      4'h3: t = `PTD_TAP_LO_3;
      4'h4: t = `PTD_TAP_LO_4;
      4'h5: t = `PTD_TAP_LO_5;
      4'h6: t = `PTD_TAP_LO_6;
      4'h7: t = `PTD_TAP_LO_7;
      4'h8: t = `PTD_TAP_HI_0;
      4'h9: t = `PTD_TAP_HI_1;
      4'hA: t = `PTD_TAP_HI_2;
      4'hB: t = `PTD_TAP_HI_3;
      4'hC: t = `PTD_TAP_HI_4;
      4'hD: t = `PTD_TAP_HI_5;
      4'hE: t = `PTD_TAP_HI_6;
      default: t = `PTD_TAP_HI_7;
    endcase
    return t;
  endfunction

  logic               timebase_on_bit_r, timebase_on_bit_nxt;
  logic               tap_range_select_r, tap_range_select_nxt;
  logic               irq_en_r, irq_en_nxt;
  ptd_pkg::ptd_rate_t rate_select_field_r, rate_select_field_nxt;
  logic               flag_r, flag_nxt;
  logic               wake_r, wake_nxt;
  ptd_pkg::ptd_cnt_t  cnt_r, cnt_nxt;
  logic [7:0]         rdata_r, rdata_nxt;
  logic [2:0]         mode_pin, mode_sync;
  logic               in_wait, in_stop, osc_on, run, tick, acc_ok;
  ptd_pkg::ptd_cnt_t  tap;

  // mode pins come from the core's power controller, treated as async
  assign mode_pin = {OSC_RUN_IN_STOP_BIT, STOP_MODE, WAIT_MODE};
  for (genvar i = 0; i < $bits(mode_pin); i++)
  begin : g_sync
    logic [1:0] s_r;
    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
        s_r <= 2'h0;
      else if (CE)
        s_r <= {s_r[0], mode_pin[i]};
    end
    // only the second stage is read, the first may be metastable
    assign mode_sync[i] = s_r[1];
  end

  always_comb
  begin
    in_wait = mode_sync[`PTD_SYNC_WAIT];
    in_stop = mode_sync[`PTD_SYNC_STOP];
    osc_on  = mode_sync[`PTD_SYNC_OSC];
    acc_ok  = !in_wait && !in_stop;
    // wait does not gate the clock; stop does unless osc kept alive
    run = timebase_on_bit_r && (!in_stop || osc_on);
    tap = tap_of(tap_range_select_r, rate_select_field_r);
    // event on the last count, so one period is exactly the tap
    tick = run && (cnt_r == tap - `PTD_CNT_ONE);
  end

  // control register, locked while the core sleeps
  always_comb
  begin
    timebase_on_bit_nxt   = timebase_on_bit_r;
    tap_range_select_nxt  = tap_range_select_r;
    irq_en_nxt            = irq_en_r;
    rate_select_field_nxt = rate_select_field_r;
    if (WR && acc_ok && ADDR == `PTD_OFF_CTRL)
    begin
      timebase_on_bit_nxt  = WDATA[`PTD_BIT_ON];
      tap_range_select_nxt = WDATA[`PTD_BIT_RANGE];
      irq_en_nxt           = WDATA[`PTD_BIT_IE];
      // rate held while running, but a range write can still change the tap
      if (!timebase_on_bit_r)
        rate_select_field_nxt = WDATA[`PTD_RATE_MSB:`PTD_RATE_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      timebase_on_bit_r   <= 1'b0;
      tap_range_select_r  <= 1'b0;
      irq_en_r            <= 1'b0;
      rate_select_field_r <= 3'h0;
    end
    else if (CE)
    begin
      timebase_on_bit_r   <= timebase_on_bit_nxt;
      tap_range_select_r  <= tap_range_select_nxt;
      irq_en_r            <= irq_en_nxt;
      rate_select_field_r <= rate_select_field_nxt;
    end
  end

  // divider: frozen, not cleared, in stop without osc so no partial period is lost
  always_comb
  begin
    if (!timebase_on_bit_r)
      cnt_nxt = '0;
    else if (!run)
      cnt_nxt = cnt_r;
    else if (tick)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + `PTD_CNT_ONE;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      cnt_r <= '0;
    else if (CE)
      cnt_r <= cnt_nxt;
  end

  // event flag and wakeup; set beats clear in the same cycle
  always_comb
  begin
    flag_nxt = flag_r;
    wake_nxt = wake_r;
    if (WR && ADDR == `PTD_OFF_STAT && WDATA[`PTD_BIT_FCLR])
    begin
      flag_nxt = 1'b0;
      wake_nxt = 1'b0;
    end
    // wakeup is a stop-only request, dropped once the core is up
    if (!in_stop)
      wake_nxt = 1'b0;
    if (tick)
    begin
      flag_nxt = 1'b1;
      if (in_stop)
        wake_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flag_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else if (CE)
    begin
      flag_r <= flag_nxt;
      wake_r <= wake_nxt;
    end
  end

  // read port: data stand for the one cycle after the strobe only
  always_comb
  begin
    rdata_nxt = `PTD_ZERO8;
    if (RD)
    begin
      case (ADDR)
        `PTD_OFF_CTRL:
          if (acc_ok)
          begin
            rdata_nxt[`PTD_BIT_ON]    = timebase_on_bit_r;
            rdata_nxt[`PTD_BIT_RANGE] = tap_range_select_r;
            rdata_nxt[`PTD_BIT_IE]    = irq_en_r;
            rdata_nxt[`PTD_RATE_MSB:`PTD_RATE_LSB] = rate_select_field_r;
          end
        `PTD_OFF_STAT: rdata_nxt[`PTD_BIT_FLAG] = flag_r;
        `PTD_OFF_CNT:  rdata_nxt = cnt_r[`PTD_CNT_W-1 -: 8];
        default:       rdata_nxt = `PTD_ZERO8;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_r <= `PTD_ZERO8;
    else if (CE)
      rdata_r <= rdata_nxt;
  end

  assign RDATA  = rdata_r;
  assign IRQ    = flag_r && irq_en_r;
  assign WAKEUP = wake_r;
endmodule
`default_nettype wire

//--- testbench/ptd_timebase_monitor.sv
// port checker for the timebase divider
`include "ptd_defs.svh"
`default_nettype none
module ptd_monitor
(
  input wire logic                   CLK,
  input wire logic                   RST_B,
  input wire logic                   CE,
  input wire logic [`PTD_ADDR_W-1:0] ADDR,
  input wire logic [7:0]             WDATA,
  input wire logic                   WR,
  input wire logic                   RD,
  input wire logic [7:0]             RDATA,
  input wire logic                   WAIT_MODE,
  input wire logic                   STOP_MODE,
  input wire logic                   OSC_RUN_IN_STOP_BIT,
  input wire logic                   IRQ,
  input wire logic                   WAKEUP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // three cycles cover the two-stage mode sync
  sequence ctrl_rd;
    RD && CE && ADDR == `PTD_OFF_CTRL;
  endsequence
  chk_rd_idle: assert property (!(RD && CE) |=> RDATA == 8'h00)
    else $error("stray read data");
  chk_wait_lock: assert property (
    WAIT_MODE[*3] ##0 ctrl_rd |=> RDATA == 8'h00)
    else $error("control readable in wait");
  chk_stop_lock: assert property (
    STOP_MODE[*3] ##0 ctrl_rd |=> RDATA == 8'h00)
    else $error("control readable in stop");
  chk_stop_quiet: assert property (
    (STOP_MODE && !OSC_RUN_IN_STOP_BIT)[*4] |-> !$rose(IRQ))
    else $error("event in stop without clock");
  chk_wake_cause: assert property (
    $rose(WAKEUP) |-> $past(STOP_MODE, 3))
    else $error("wakeup outside stop");
  chk_wake_hold: assert property (
    (WAKEUP && STOP_MODE && !WR)[*3] |=> WAKEUP)
    else $error("wakeup dropped");
  chk_irq_clear: assert property ($fell(IRQ) |-> $past(WR && CE))
    else $error("irq fell without write");
  chk_ce_freeze: assert property (!CE |=> $stable(IRQ) && $stable(WAKEUP))
    else $error("outputs moved while frozen");
endmodule
bind ptd_timebase ptd_monitor u_mon (.*);
`default_nettype wire

//--- testbench/test_periodic_timebase_divider.sv
// self-checking bench for the timebase divider
`include "ptd_defs.svh"
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_periodic_timebase_divider;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   CLK = 0, RST_B = 0, CE = 1, WR = 0, RD = 0;
  logic                   WAIT_MODE = 0, STOP_MODE = 0;
  logic                   OSC_RUN_IN_STOP_BIT = 0;
  logic [`PTD_ADDR_W-1:0] ADDR = 0;
  logic [7:0]             WDATA = 0;
  wire logic [7:0]        RDATA;
  wire logic              IRQ, WAKEUP;
  int                     err_total = 0, checks_done = 0;
  time                    t0, ta;
  ptd_timebase DUT
  (
    .CLK                 (CLK),
    .RST_B               (RST_B),
    .CE                  (CE),
    .ADDR                (ADDR),
    .WDATA               (WDATA),
    .WR                  (WR),
    .RD                  (RD),
    .RDATA               (RDATA),
    .WAIT_MODE           (WAIT_MODE),
    .STOP_MODE           (STOP_MODE),
    .OSC_RUN_IN_STOP_BIT (OSC_RUN_IN_STOP_BIT),
    .IRQ                 (IRQ),
    .WAKEUP              (WAKEUP)
  );
  always #2.5 CLK = ~CLK;
  task report_and_stop;
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge CLK);
    WR <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge CLK);
    RD <= 0;
    @(negedge CLK);
    `CHK(RDATA, e)
  endtask
  // w selects wakeup instead of irq
  task await(input logic w, input int n = 300);
    repeat (n)
    begin
      @(negedge CLK);
      if ((w ? WAKEUP : IRQ) === 1'b1)
      begin
        t0 = $time;
        return;
      end
    end
    err_total++;
    report_and_stop();
  endtask
  task hold(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task sc_basic;
    rd(`PTD_OFF_CTRL, `PTD_CTRL_RST);
    rd(4'hC, 8'h00);
    wr(`PTD_OFF_CTRL, 8'h75);
    await(0);
    ta = t0;
    rd(`PTD_OFF_STAT, 8'h01);
    hold(1);
    CE <= 0;
    hold(4);
    CE <= 1;
    wr(`PTD_OFF_STAT, 8'h02);
    await(0);
    ta = t0;
    wr(`PTD_OFF_STAT, 8'h02);
    await(0);
    `CHK(t0 - ta, 64'h28)
    wr(`PTD_OFF_CTRL, 8'h05);
    rd(`PTD_OFF_CTRL, 8'h75);
  endtask
  task sc_wait;
    hold(1);
    WAIT_MODE <= 1;
    hold(3);
    rd(`PTD_OFF_CTRL, 8'h00);
    wr(`PTD_OFF_CTRL, 8'h00);
    wr(`PTD_OFF_STAT, 8'h02);
    await(0);
    hold(1);
    WAIT_MODE <= 0;
    hold(3);
    rd(`PTD_OFF_CTRL, 8'h75);
  endtask
  task sc_stop;
    hold(1);
    STOP_MODE <= 1;
    OSC_RUN_IN_STOP_BIT <= 1;
    hold(3);
    rd(`PTD_OFF_CTRL, 8'h00);
    wr(`PTD_OFF_CTRL, 8'h00);
    wr(`PTD_OFF_STAT, 8'h02);
    await(1);
    hold(1);
    OSC_RUN_IN_STOP_BIT <= 0;
    hold(3);
    wr(`PTD_OFF_STAT, 8'h02);
    hold(40);
    @(negedge CLK);
    `CHK({IRQ, WAKEUP}, 2'h0)
    hold(1);
    STOP_MODE <= 0;
    hold(3);
    rd(`PTD_OFF_CTRL, 8'h75);
  endtask
  task sc_off;
    wr(`PTD_OFF_CTRL, 8'h04);
    wr(`PTD_OFF_STAT, 8'h02);
    hold(1);
    WAIT_MODE <= 1;
    hold(40);
    @(negedge CLK);
    `CHK(IRQ, 1'b0)
    hold(1);
    WAIT_MODE <= 0;
    STOP_MODE <= 1;
    hold(40);
    @(negedge CLK);
    `CHK({IRQ, WAKEUP}, 2'h0)
    hold(1);
    STOP_MODE <= 0;
    hold(3);
    rd(`PTD_OFF_CNT, 8'h00);
  endtask
  // upper range, shortest tap: 1024 cycles between events
  task sc_range;
    wr(`PTD_OFF_CTRL, 8'h77);
    await(0, 1100);
    ta = t0;
    wr(`PTD_OFF_STAT, 8'h02);
    await(0, 1100);
    `CHK(t0 - ta, 64'h1400)
  endtask
  initial
  begin
    hold(3);
    RST_B <= 1;
    sc_basic();
    sc_wait();
    sc_stop();
    sc_off();
    sc_range();
    report_and_stop();
  end
endmodule
`default_nettype wire
